// ===== src/spi_pkg.sv
// constants for the select-synchronised serial slave port
// assumes an 8-bit register port with 4-bit byte addresses
package spi_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 4;
	localparam int CNT_W = 3;

	// register byte addresses
	localparam logic [ADDR_W-1:0] ADDR_CTL_ONE = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_CTL_THREE = 4'h4;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h8;
	localparam logic [ADDR_W-1:0] ADDR_DATA = 4'hc;

	// port_control_one fields
	localparam int MODE_LSB = 0;
	localparam int MODE_W = 4;
	localparam int POL_BIT = 4;
	localparam int EN_BIT = 5;
	localparam int CKE_BIT = 6;
	localparam logic [MODE_W-1:0] MODE_SLAVE_SEL = 4'h4;

	// port_control_three fields
	localparam int OVERWRITE_BIT = 0;
	localparam int WAKE_EN_BIT = 1;

	// port_status_reg fields
	localparam int PHASE_BIT = 0;
	localparam int FULL_BIT = 1;
	localparam int OVF_BIT = 2;
	localparam int IRQ_BIT = 3;
	localparam int SCK_LVL_BIT = 4;
	localparam int SEL_LVL_BIT = 5;
	localparam int TX_PEND_BIT = 6;

	// reset values and masks
	localparam logic [DATA_W-1:0] CTL_ONE_RST = 8'h00;
	localparam logic [DATA_W-1:0] CTL_ONE_MASK = 8'h7f;
	localparam logic [DATA_W-1:0] CTL_THREE_RST = 8'h00;
	localparam logic [DATA_W-1:0] CTL_THREE_MASK = 8'h03;
	localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
	localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
	localparam logic [CNT_W-1:0] CNT_LAST = 3'h7;
endpackage

// ===== src/sync_2ff.sv
// two flip-flop level synchroniser into the clock of the receiving side
// assumes the source is a level that stays put for several cycles
module sync_2ff #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// level in and out
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	always_comb begin
		meta_d = rst_n_in ? async_in : RST_VAL;
		sync_d = rst_n_in ? meta_q : RST_VAL;
	end

	// first stage feeds only the second stage
	always_ff @(posedge clk_in) begin
		meta_q <= meta_d;
		sync_q <= sync_d;
	end

	assign sync_out = sync_q;
endmodule

// ===== src/spi_slave_select_sync.sv
// serial slave port with select-pin framing and a register port
// assumes sck_in comes from the master, which also drives ss_n_in;
// clock polarity, edge and transmit byte are held steady during a frame
//
// The strobed register port and the placing of the registers were decided locally.

module spi_slave_select_sync
	import spi_pkg::*;
(
	// system clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// register port
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [DATA_W-1:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [DATA_W-1:0] rdata_out,
	// serial link pins
	input wire logic sck_in,
	input wire logic ss_n_in,
	input wire logic serial_data_in,
	output logic serial_data_out,
	output logic serial_data_oe_out,
	// events
	output logic port_irq_flag_out,
	output logic wake_out
);
	// system domain state
	logic [DATA_W-1:0] port_control_one_q;
	logic [DATA_W-1:0] port_control_one_d;
	logic [DATA_W-1:0] port_control_three_q;
	logic [DATA_W-1:0] port_control_three_d;
	logic [DATA_W-1:0] port_data_buffer_q;
	logic [DATA_W-1:0] port_data_buffer_d;
	logic [DATA_W-1:0] tx_byte_q;
	logic [DATA_W-1:0] tx_byte_d;
	logic [DATA_W-1:0] rdata_q;
	logic [DATA_W-1:0] rdata_d;
	logic sample_phase_bit_q;
	logic sample_phase_bit_d;
	logic full_q;
	logic full_d;
	logic overflow_q;
	logic overflow_d;
	logic port_irq_flag_q;
	logic port_irq_flag_d;
	logic tx_pending_q;
	logic tx_pending_d;
	logic rx_seen_q;
	logic rx_seen_d;
	logic link_en_q;
	logic link_en_d;
	logic link_clr_q;
	logic link_clr_d;
	logic drive_q;
	logic drive_d;
	logic wake_q;
	logic wake_d;

	// link domain state
	logic [CNT_W-1:0] bit_cnt_q;
	logic [CNT_W-1:0] bit_cnt_d;
	logic [DATA_W-1:0] shreg_q;
	logic [DATA_W-1:0] shreg_d;
	logic [DATA_W-1:0] rx_word_q;
	logic [DATA_W-1:0] rx_word_d;
	logic rx_tog_q;
	logic rx_tog_d;
	logic out_bit_q;
	logic out_bit_d;
	logic lead_bit_q;
	logic lead_bit_d;

	// crossings and decoded fields
	logic sck_s;
	logic ss_n_s;
	logic rx_tog_s;
	logic rx_event;
	logic mode_ok;
	logic clock_polarity_bit;
	logic cke;
	logic buffer_overwrite_enable;
	logic wake_en;
	logic shift_clk;
	logic link_rst;
	logic [DATA_W-1:0] src_byte;
	logic [DATA_W-1:0] status_view;

	assign clock_polarity_bit = port_control_one_q[POL_BIT];
	assign cke = port_control_one_q[CKE_BIT];
	assign buffer_overwrite_enable = port_control_three_q[OVERWRITE_BIT];
	assign wake_en = port_control_three_q[WAKE_EN_BIT];
	assign mode_ok = port_control_one_q[MODE_LSB +: MODE_W] == MODE_SLAVE_SEL;

	// pin levels and the byte toggle come into the system clock
	sync_2ff #(
		.WIDTH(1),
		.RST_VAL(1'b0)
	) u_sync_sck (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.async_in(sck_in),
		.sync_out(sck_s)
	);

	sync_2ff #(
		.WIDTH(1),
		.RST_VAL(1'b1)
	) u_sync_ss (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.async_in(ss_n_in),
		.sync_out(ss_n_s)
	);

	sync_2ff #(
		.WIDTH(1),
		.RST_VAL(1'b0)
	) u_sync_tog (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.async_in(rx_tog_q),
		.sync_out(rx_tog_s)
	);

	assign rx_event = rx_tog_s != rx_seen_q;

	// link clock: idle level from polarity, sample edge from edge select.
	// a change of either bit glitches this clock, so set them between frames
	assign shift_clk = sck_in ^ clock_polarity_bit ^ cke;

	// select high or a disabled port holds the shift register, bit count and output bit in reset
	assign link_rst = ss_n_in | ~link_en_q;

	// first bit of a byte comes from the written byte, else the last byte in
	always_comb begin
		if (bit_cnt_q == CNT_ZERO && tx_pending_q) begin
			src_byte = tx_byte_q;
		end else begin
			src_byte = shreg_q;
		end
	end

	// link sampling edge: shift in, count, hand the byte over
	always_comb begin
		shreg_d = {src_byte[DATA_W-2:0], serial_data_in};
		// with edge select clear, the bit leaving the byte here goes out on the next drive edge
		lead_bit_d = src_byte[DATA_W-1];
		bit_cnt_d = bit_cnt_q + 3'h1;
		rx_word_d = rx_word_q;
		rx_tog_d = rx_tog_q;
		if (bit_cnt_q == CNT_LAST) begin
			rx_word_d = {src_byte[DATA_W-2:0], serial_data_in};
			rx_tog_d = ~rx_tog_q;
		end
	end

	always_ff @(posedge shift_clk or posedge link_rst) begin
		if (link_rst) begin
			shreg_q <= BYTE_ZERO;
			lead_bit_q <= 1'b0;
			bit_cnt_q <= CNT_ZERO;
		end else begin
			shreg_q <= shreg_d;
			lead_bit_q <= lead_bit_d;
			bit_cnt_q <= bit_cnt_d;
		end
	end

	// byte handover survives frame ends; only a system reset clears it
	always_ff @(posedge shift_clk or posedge link_clr_q) begin
		if (link_clr_q) begin
			rx_word_q <= BYTE_ZERO;
			rx_tog_q <= 1'b0;
		end else begin
			rx_word_q <= rx_word_d;
			rx_tog_q <= rx_tog_d;
		end
	end

	// link drive edge: present the next bit half a clock before sampling
	// edge select clear drives after each sample, so it sends the bit that
	// sample pushed out; edge select set drives before sampling
	always_comb begin
		out_bit_d = cke ? src_byte[DATA_W-1] : lead_bit_q;
	end

	always_ff @(negedge shift_clk or posedge link_rst) begin
		if (link_rst) begin
			out_bit_q <= 1'b0;
		end else begin
			out_bit_q <= out_bit_d;
		end
	end

	// software's view of the status bits
	always_comb begin
		status_view = BYTE_ZERO;
		status_view[PHASE_BIT] = sample_phase_bit_q;
		status_view[FULL_BIT] = full_q;
		status_view[OVF_BIT] = overflow_q;
		status_view[IRQ_BIT] = port_irq_flag_q;
		status_view[SCK_LVL_BIT] = sck_s;
		status_view[SEL_LVL_BIT] = ss_n_s;
		status_view[TX_PEND_BIT] = tx_pending_q;
	end

	// register port, byte intake and flags
	always_comb begin
		port_control_one_d = port_control_one_q;
		port_control_three_d = port_control_three_q;
		port_data_buffer_d = port_data_buffer_q;
		tx_byte_d = tx_byte_q;
		sample_phase_bit_d = sample_phase_bit_q;
		full_d = full_q;
		overflow_d = overflow_q;
		port_irq_flag_d = port_irq_flag_q;
		tx_pending_d = tx_pending_q;
		rx_seen_d = rx_tog_s;
		rdata_d = BYTE_ZERO;

		if (wr_in) begin
			unique case (addr_in)
				ADDR_CTL_ONE: begin
					port_control_one_d = wdata_in & CTL_ONE_MASK;
				end
				ADDR_CTL_THREE: begin
					port_control_three_d = wdata_in & CTL_THREE_MASK;
				end
				ADDR_STATUS: begin
					// kept as written; the slave never uses it
					sample_phase_bit_d = wdata_in[PHASE_BIT];
					if (wdata_in[OVF_BIT]) begin
						overflow_d = 1'b0;
					end
					if (wdata_in[IRQ_BIT]) begin
						port_irq_flag_d = 1'b0;
					end
				end
				ADDR_DATA: begin
					tx_byte_d = wdata_in;
					tx_pending_d = 1'b1;
				end
				default: begin
				end
			endcase
		end

		if (rd_in) begin
			unique case (addr_in)
				ADDR_CTL_ONE: begin
					rdata_d = port_control_one_q;
				end
				ADDR_CTL_THREE: begin
					rdata_d = port_control_three_q;
				end
				ADDR_STATUS: begin
					rdata_d = status_view;
				end
				ADDR_DATA: begin
					rdata_d = port_data_buffer_q;
					full_d = 1'b0;
				end
				default: begin
					rdata_d = BYTE_ZERO;
				end
			endcase
		end

		// a byte arriving beside a clear or a read wins over it
		if (rx_event) begin
			port_irq_flag_d = 1'b1;
			tx_pending_d = 1'b0;
			// a read in this cycle frees the buffer for the new byte
			if (full_d && !buffer_overwrite_enable) begin
				overflow_d = 1'b1;
			end else begin
				port_data_buffer_d = rx_word_q;
				full_d = 1'b1;
			end
		end
	end

	// enables, output driver and wake request
	always_comb begin
		link_en_d = port_control_one_q[EN_BIT] && mode_ok;
		link_clr_d = ~rst_n_in;
		// released a synchroniser delay after select rises
		drive_d = link_en_q && !ss_n_s;
		wake_d = port_irq_flag_q && wake_en;
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			port_control_one_q <= CTL_ONE_RST;
			port_control_three_q <= CTL_THREE_RST;
			port_data_buffer_q <= BYTE_ZERO;
			tx_byte_q <= BYTE_ZERO;
			rdata_q <= BYTE_ZERO;
			sample_phase_bit_q <= 1'b0;
			full_q <= 1'b0;
			overflow_q <= 1'b0;
			port_irq_flag_q <= 1'b0;
			tx_pending_q <= 1'b0;
			rx_seen_q <= 1'b0;
			link_en_q <= 1'b0;
			link_clr_q <= 1'b1;
			drive_q <= 1'b0;
			wake_q <= 1'b0;
		end else begin
			port_control_one_q <= port_control_one_d;
			port_control_three_q <= port_control_three_d;
			port_data_buffer_q <= port_data_buffer_d;
			tx_byte_q <= tx_byte_d;
			rdata_q <= rdata_d;
			sample_phase_bit_q <= sample_phase_bit_d;
			full_q <= full_d;
			overflow_q <= overflow_d;
			port_irq_flag_q <= port_irq_flag_d;
			tx_pending_q <= tx_pending_d;
			rx_seen_q <= rx_seen_d;
			link_en_q <= link_en_d;
			link_clr_q <= link_clr_d;
			drive_q <= drive_d;
			wake_q <= wake_d;
		end
	end

	assign rdata_out = rdata_q;
	assign serial_data_out = out_bit_q;
	assign serial_data_oe_out = drive_q;
	assign port_irq_flag_out = port_irq_flag_q;
	assign wake_out = wake_q;
endmodule

// ===== verif/spi_slave_select_sync_properties.sv
// assertions on the ports of the select-framed serial slave
// assumes binding into spi_slave_select_sync
module spi_slave_select_sync_properties
	import spi_pkg::*;
(
	// clock, reset, register port
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [DATA_W-1:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [DATA_W-1:0] rdata_out,
	// link pins and events
	input wire logic ss_n_in,
	input wire logic serial_data_out,
	input wire logic serial_data_oe_out,
	input wire logic port_irq_flag_out,
	input wire logic wake_out
);
	// cycles since select was last low; saturates so it never wraps
	logic [3:0] hi_q;
	always_ff @(posedge clk_in) begin
		hi_q <= (!rst_n_in || !ss_n_in) ? 4'h0 : hi_q + {3'h0, hi_q != 4'hf};
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	chk_oe_release: assert property (
		ss_n_in [*4] |-> !serial_data_oe_out)
		else $error("output enable held with select high");
	chk_oe_framed: assert property (
		$rose(serial_data_oe_out) |-> !$past(ss_n_in, 2))
		else $error("output enable rose without select");
	chk_out_idle: assert property (
		ss_n_in |-> !serial_data_out)
		else $error("serial output not reset by select");
	chk_wake_flag: assert property (
		wake_out |-> $past(port_irq_flag_out))
		else $error("wake without flag");
	chk_flag_sticky: assert property (
		$fell(port_irq_flag_out) |-> $past(wr_in) &&
		$past(addr_in) == ADDR_STATUS && $past(wdata_in[IRQ_BIT]))
		else $error("flag dropped without clear");
	chk_flag_framed: assert property (
		$rose(port_irq_flag_out) |-> hi_q < 4'h8)
		else $error("flag rose outside a frame");
	chk_flag_clear: assert property (
		wr_in && addr_in == ADDR_STATUS && wdata_in[IRQ_BIT] && hi_q > 4'h8
		|=> !port_irq_flag_out)
		else $error("flag clear ignored");
	chk_rdata_idle: assert property (
		!$past(rd_in) |-> rdata_out == BYTE_ZERO)
		else $error("read data outside read slot");
endmodule

bind spi_slave_select_sync spi_slave_select_sync_properties props (
	.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
	.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
	.rdata_out(rdata_out), .ss_n_in(ss_n_in),
	.serial_data_out(serial_data_out),
	.serial_data_oe_out(serial_data_oe_out),
	.port_irq_flag_out(port_irq_flag_out), .wake_out(wake_out));

// ===== verif/spi_master_model.sv
// far-side serial master: clock, select and data into the slave
// assumes the bench sets the clock idle level on cpol_in
module spi_master_model (
	// idle level
	input wire logic cpol_in,
	// link pins
	input wire logic miso_in,
	output logic sck_out,
	output logic ss_n_out,
	output logic mosi_out
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		sck_out = 1'b0;
		ss_n_out = 1'b1;
		mosi_out = 1'b0;
	end
	// clock rests at its idle level outside frames
	always @(cpol_in, ss_n_out) if (ss_n_out) sck_out = cpol_in;
	task automatic frame(input logic on);
		ss_n_out = !on;
		if (!on)
			mosi_out = !mosi_out; // released line keeps no stale bit
		#100;
	endtask
	// capture after the trailing edge, where either edge mode has settled
	task automatic shift(input logic [7:0] tx, input int nb,
		output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 0; i < nb; i++) begin
			mosi_out = tx[7 - i];
			#52.5;
			sck_out = !sck_out;
			#62.5;
			sck_out = !sck_out;
			#10;
			rx = {rx[6:0], miso_in};
		end
	endtask
endmodule

// ===== verif/spi_slave_select_sync_tb.sv
// self-checking bench for the select-framed serial slave
// assumes spi_master_model stands in for the far-side master
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
	miscompares++; $display("ERROR %0t got %h exp %h", $time, a, e); end end
module spi_slave_select_sync_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import spi_pkg::*;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [ADDR_W-1:0] addr_in = '0;
	logic [DATA_W-1:0] wdata_in = '0;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic cpol = 1'b0;
	logic sck, ss_n, mosi, slave_out, oe, flag, wake;
	logic [DATA_W-1:0] rdata_out;
	logic [7:0] rx;
	int miscompares = 0;
	int samples_checked = 0;
	int cycles = 0;
	always #10 clk_in = !clk_in;
	spi_slave_select_sync dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
		.rd_in(rd_in), .rdata_out(rdata_out), .sck_in(sck),
		.ss_n_in(ss_n), .serial_data_in(mosi), .serial_data_out(slave_out),
		.serial_data_oe_out(oe), .port_irq_flag_out(flag),
		.wake_out(wake));
	// a released output shows the inverse of its bit, so a capture taken
	// while the driver is off cannot pass by luck
	spi_master_model m (.cpol_in(cpol),
		.miso_in(oe ? slave_out : !slave_out), .sck_out(sck),
		.ss_n_out(ss_n), .mosi_out(mosi));
	task automatic wreg(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= v;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask
	task automatic rchk(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1 `CHK(rdata_out, e)
	endtask
	task automatic xfer(input logic [7:0] tx, input int nb);
		m.frame(1'b1);
		m.shift(tx, nb, rx);
		m.frame(1'b0);
		repeat (10) @(posedge clk_in);
	endtask
	task automatic s_regs();
		rchk(ADDR_CTL_ONE, CTL_ONE_RST);
		rchk(ADDR_CTL_THREE, CTL_THREE_RST);
		rchk(4'h1, BYTE_ZERO); // unmapped
		wreg(ADDR_CTL_ONE, 8'hbf);
		rchk(ADDR_CTL_ONE, 8'h3f);
		wreg(ADDR_CTL_ONE, 8'h24);
		wreg(ADDR_CTL_THREE, 8'h03);
	endtask
	task automatic s_byte();
		wreg(ADDR_DATA, 8'ha5);
		xfer(8'h3c, 8);
		`CHK(rx, 8'ha5)
		`CHK(flag, 1'b1)
		`CHK(wake, 1'b1)
		`CHK(oe, 1'b0)
		rchk(ADDR_DATA, 8'h3c);
		wreg(ADDR_STATUS, 8'h0c);
		#1 `CHK(flag, 1'b0)
	endtask
	task automatic s_chain();
		m.frame(1'b1);
		m.shift(8'h5a, 8, rx);
		`CHK(rx, 8'h00)
		`CHK(oe, 1'b1)
		m.shift(8'hc3, 8, rx);
		`CHK(rx, 8'h5a)
		m.frame(1'b0);
		repeat (10) @(posedge clk_in);
		rchk(ADDR_DATA, 8'hc3);
	endtask
	task automatic s_overrun();
		wreg(ADDR_CTL_THREE, 8'h02);
		xfer(8'hb1, 8);
		xfer(8'hb2, 8);
		rchk(ADDR_STATUS, 8'h2e);
		rchk(ADDR_DATA, 8'hb1);
		wreg(ADDR_CTL_THREE, 8'h03);
	endtask
	task automatic s_partial();
		xfer(8'hff, 3);
		xfer(8'h81, 8);
		rchk(ADDR_DATA, 8'h81);
	endtask
	task automatic s_mode();
		wreg(ADDR_STATUS, 8'h0c);
		wreg(ADDR_CTL_ONE, 8'h23);
		xfer(8'h11, 8);
		`CHK(flag, 1'b0)
		wreg(ADDR_CTL_ONE, 8'h04);
		xfer(8'h22, 8);
		`CHK(flag, 1'b0)
	endtask
	task automatic s_polarity();
		@(posedge clk_in) cpol <= 1'b1;
		wreg(ADDR_CTL_ONE, 8'h34);
		wreg(ADDR_DATA, 8'h3a);
		xfer(8'h96, 8);
		`CHK(rx, 8'h3a)
		rchk(ADDR_DATA, 8'h96);
	endtask
	task automatic s_edge();
		wreg(ADDR_CTL_ONE, 8'h04);
		@(posedge clk_in) cpol <= 1'b0;
		wreg(ADDR_CTL_ONE, 8'h64);
		wreg(ADDR_DATA, 8'h69);
		xfer(8'h4b, 8);
		`CHK(rx, 8'h69)
		rchk(ADDR_DATA, 8'h4b);
	endtask
	task automatic conclude();
		$display("checked %0d mismatched %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// the whole run needs about 800 cycles
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			conclude();
		end
	end
	initial begin
		repeat (3) @(posedge clk_in);
		rst_n_in <= 1'b1;
		s_regs();
		s_byte();
		s_chain();
		s_overrun();
		s_partial();
		s_mode();
		s_polarity();
		s_edge();
		conclude();
	end
endmodule
